// [irq_front_pkg.sv]
// shared constants and carrier types for the interrupt and nmi request front end
package irq_front_pkg;

  localparam int unsigned NUM_IO_REQ  = 6;   // request lines 2..7
  localparam int unsigned NUM_NMI_SRC = 3;

  // nmi status and enable bit positions
  localparam int unsigned NMI_BIT_COPROC = 0;
  localparam int unsigned NMI_BIT_CLOCK  = 1;
  localparam int unsigned NMI_BIT_POWER  = 2;

  localparam logic [5:0] IO_REQ_RESET     = 6'h00;
  localparam logic [2:0] NMI_STATUS_RESET = 3'h0;

  typedef struct packed {
    logic power_fail_nmi_in;
    logic clock_chip_nmi_in;
    logic coproc_error_nmi_in;
  } nmi_src_t;

  typedef struct packed {
    logic oe;   // high while the block pulls the pin low
    logic o;    // always low: open drain
  } od_drive_t;

endpackage

// [irq_front_sva.sv]
// assertions for the request front end
`timescale 1ns/1ps
module irq_front_sva (
  input wire logic mclk, rst, ext_kbd_sel, nmi_status_clear, nmi_out, shared_request_one, kbd_serial_data,
  input wire logic kbd_clock_or_request_pin_i, kbd_clock_or_request_pin_oe, kbd_serial_clock, kbd_serial_line_oe,
  input wire logic [5:0] io_req_in, io_req_pending,
  input wire logic [2:0] nmi_enable, nmi_status,
  input wire irq_front_pkg::nmi_src_t nmi_src
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // two sync stages sit between the pin and the status bit
  sequence rise_en(s, e); $rose(s) ##2 e; endsequence
  a_req_edge: assert property ($rose(io_req_in[0]) |=> io_req_pending[0])
    else $error("request edge not latched");
  a_coproc_nmi: assert property (rise_en(nmi_src.coproc_error_nmi_in, nmi_enable[0]) |=> nmi_status[0])
    else $error("coprocessor nmi lost");
  a_clock_nmi: assert property (rise_en(nmi_src.clock_chip_nmi_in, nmi_enable[1]) |=> nmi_status[1])
    else $error("clock chip nmi lost");
  a_power_nmi: assert property (rise_en(nmi_src.power_fail_nmi_in, nmi_enable[2]) |=> nmi_status[2])
    else $error("power fail nmi lost");
  a_nmi_cause: assert property (nmi_out == (|nmi_status))
    else $error("nmi out differs from status");
  a_status_sticky: assert property (!nmi_status_clear |=> (nmi_status & $past(nmi_status)) == $past(nmi_status))
    else $error("status dropped without clear");
  a_pin_mode: assert property (ext_kbd_sel |-> !kbd_clock_or_request_pin_oe && !kbd_serial_clock)
    else $error("pin still keyboard clock");
  a_shared_req: assert property (ext_kbd_sel && $rose(kbd_clock_or_request_pin_i) |=> shared_request_one)
    else $error("request one lost");
  a_data_unused: assert property (ext_kbd_sel |-> !kbd_serial_line_oe ##1 $stable(kbd_serial_data))
    else $error("data pin used");
endmodule // irq_front_sva
bind irq_nmi_request_front_end irq_front_sva i_irq_front_sva (.*);

// [irq_nmi_request_front_end.sv]
// interrupt and nmi request front end with shared keyboard clock / request pin
`timescale 1ns/1ps

module irq_nmi_request_front_end (
  input  wire logic                  mclk,                  // 25 MHz clock
  input  wire logic                  rst,                   // sync reset, active high
  input  wire logic [5:0]            io_req_in,             // request lines 2..7 (bit 0 = line 2)
  input  wire logic [5:0]            io_req_ack,            // pulse: clears a latched request
  output logic      [5:0]            io_req_pending,        // latched requests 2..7
  input  wire irq_front_pkg::nmi_src_t nmi_src,             // three asynchronous nmi sources
  input  wire logic [2:0]            nmi_enable,            // per-source nmi enable
  input  wire logic                  nmi_status_clear,      // pulse: clears status bits given in mask
  input  wire logic [2:0]            nmi_clear_mask,        // which status bits to clear
  output logic      [2:0]            nmi_status,            // sticky nmi cause bits
  output logic                       nmi_out,               // nmi to the cpu, level
  input  wire logic                  ext_kbd_sel,           // config: external keyboard interface
  input  wire logic                  kbd_clock_or_request_pin_i, // shared pin level
  input  wire logic                  kbd_clock_drive_low,   // keyboard logic wants the clock low
  output logic                       kbd_clock_or_request_pin_o, // shared pin output value
  output logic                       kbd_clock_or_request_pin_oe, // shared pin output enable
  output logic                       kbd_serial_clock,      // pin as keyboard clock
  output logic                       shared_request_one,    // latched request one
  input  wire logic                  shared_request_one_ack, // pulse: clears request one
  input  wire logic                  kbd_serial_line_i,     // keyboard data pin level
  input  wire logic                  kbd_data_drive_low,    // keyboard logic wants data low
  output logic                       kbd_serial_line_o,     // data pin output value
  output logic                       kbd_serial_line_oe,    // data pin output enable
  output logic                       kbd_serial_data        // sampled keyboard data
);

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers

  // rising edge of a level against its value one clock earlier
  function automatic logic rise_of(input logic now_level, input logic last_level);
    rise_of = now_level & ~last_level;
  endfunction

  // sticky bit: a set in the clear cycle wins, so no event is lost
  function automatic logic sticky_next(input logic cur, input logic set_now, input logic clr_now);
    sticky_next = set_now | (cur & ~clr_now);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  // one configuration bit picks the pin personality; all below keys off it
  wire req_one_mode  = ext_kbd_sel;    // pin is shared request one
  wire kbd_mode      = ~ext_kbd_sel;   // pin is keyboard clock
  wire data_pin_live = kbd_mode;       // data pin serves the keyboard logic only

  ////////////////////////////////////////////////////////////////////////////
  // io request edge latches

  logic [5:0] io_req_prev;
  wire  [5:0] io_req_rise;
  wire  [5:0] next_io_req_pending;

  // devices keep the line high until acknowledged, so one edge is one request
  generate
    for (genvar i = 0; i < irq_front_pkg::NUM_IO_REQ; i++) begin : g_io
      assign io_req_rise[i]         = rise_of(io_req_in[i], io_req_prev[i]);
      // a new edge in the ack cycle wins over the ack
      assign next_io_req_pending[i] = sticky_next(io_req_pending[i], io_req_rise[i], io_req_ack[i]);

      always_ff @(posedge mclk) begin
        if (rst) begin
          io_req_prev[i] <= irq_front_pkg::IO_REQ_RESET[i];
        end else begin
          io_req_prev[i] <= io_req_in[i];
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          io_req_pending[i] <= irq_front_pkg::IO_REQ_RESET[i];
        end else begin
          io_req_pending[i] <= next_io_req_pending[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // nmi sources: two-flop synchroniser, edge detect, sticky status

  wire  [2:0] nmi_raw = nmi_src;
  logic [2:0] nmi_meta;
  logic [2:0] nmi_sync;
  logic [2:0] nmi_prev;
  wire  [2:0] nmi_rise;
  wire  [2:0] nmi_set;
  wire  [2:0] nmi_clr;
  wire  [2:0] next_nmi_status;

  generate
    for (genvar k = 0; k < irq_front_pkg::NUM_NMI_SRC; k++) begin : g_nmi
      // only the second stage reads the first; the first may be metastable
      always_ff @(posedge mclk) begin
        if (rst) begin
          nmi_meta[k] <= 1'h0;
          nmi_sync[k] <= 1'h0;
        end else begin
          nmi_meta[k] <= nmi_raw[k];
          nmi_sync[k] <= nmi_meta[k];
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          nmi_prev[k] <= 1'h0;
        end else begin
          nmi_prev[k] <= nmi_sync[k];
        end
      end

      assign nmi_rise[k]        = rise_of(nmi_sync[k], nmi_prev[k]);
      // a disabled source records nothing and raises no nmi
      assign nmi_set[k]         = nmi_rise[k] & nmi_enable[k];
      assign nmi_clr[k]         = nmi_status_clear & nmi_clear_mask[k];
      assign next_nmi_status[k] = sticky_next(nmi_status[k], nmi_set[k], nmi_clr[k]);

      always_ff @(posedge mclk) begin
        if (rst) begin
          nmi_status[k] <= irq_front_pkg::NMI_STATUS_RESET[k];
        end else begin
          nmi_status[k] <= next_nmi_status[k];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // nmi to the cpu

  wire coproc_cause = nmi_status[irq_front_pkg::NMI_BIT_COPROC];
  wire clock_cause  = nmi_status[irq_front_pkg::NMI_BIT_CLOCK];
  wire power_cause  = nmi_status[irq_front_pkg::NMI_BIT_POWER];

  // nmi stays asserted while any cause is still recorded; software reads
  // the status to tell them apart and clears the bits it has handled
  assign nmi_out = coproc_cause | clock_cause | power_cause;

  ////////////////////////////////////////////////////////////////////////////
  // shared keyboard clock / request one pin

  logic pin_prev;
  wire  pin_rise     = rise_of(kbd_clock_or_request_pin_i, pin_prev);
  wire  req_one_rise = req_one_mode & pin_rise;
  // leaving request mode drops a pending request so it cannot fire later
  wire  req_one_clr  = shared_request_one_ack | kbd_mode;
  wire  next_shared_request_one = sticky_next(shared_request_one, req_one_rise, req_one_clr);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_prev <= 1'h0;
    end else begin
      pin_prev <= kbd_clock_or_request_pin_i;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      shared_request_one <= 1'h0;
    end else begin
      shared_request_one <= next_shared_request_one;
    end
  end

  // clock function only by default; in request mode the pin is input only
  assign kbd_serial_clock = kbd_mode & kbd_clock_or_request_pin_i;

  ////////////////////////////////////////////////////////////////////////////
  // open drain pin drivers

  // both pins only ever pull low, so the value is fixed and the enable decides
  irq_front_pkg::od_drive_t clock_pin_drive;
  irq_front_pkg::od_drive_t data_pin_drive;

  assign clock_pin_drive = '{oe: kbd_mode & kbd_clock_drive_low, o: 1'h0};
  assign data_pin_drive  = '{oe: data_pin_live & kbd_data_drive_low, o: 1'h0};

  assign kbd_clock_or_request_pin_o  = clock_pin_drive.o;
  assign kbd_clock_or_request_pin_oe = clock_pin_drive.oe;
  assign kbd_serial_line_o           = data_pin_drive.o;
  assign kbd_serial_line_oe          = data_pin_drive.oe;

  ////////////////////////////////////////////////////////////////////////////
  // keyboard data pin sample, frozen in external keyboard mode

  wire next_kbd_serial_data = data_pin_live ? kbd_serial_line_i : kbd_serial_data;

  always_ff @(posedge mclk) begin
    if (rst) begin
      kbd_serial_data <= 1'h1;
    end else begin
      kbd_serial_data <= next_kbd_serial_data;
    end
  end

endmodule // irq_nmi_request_front_end

// [irq_peripherals.sv]
// peripherals raising request lines
`timescale 1ns/1ps
module irq_peripherals (
  input  wire logic       mclk, rst, // clock, reset
  input  wire logic [5:0] raise, ack, // start, acknowledge
  output logic      [5:0] req        // request lines
);
  always_ff @(posedge mclk) req <= rst ? 6'h00 : (req | raise) & ~ack;
endmodule // irq_peripherals

// [testbench.sv]
// self-checking bench for the request front end
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, rst = 1, ext = 0, clr = 0, ack1 = 0, cd = 0, dd = 0, pr = 0, lr = 0;
  logic [5:0] raise = 0, ack = 0, req, pend, e_pend, r_prev;
  logic [2:0] en = 0, mask = 0, stat, e_stat, s1, s2, sp;
  irq_front_pkg::nmi_src_t src = 0;
  logic nout, oe, doe, kclk, sr, e_sr, pprev, kd, e_kd, pin, line, po, lo;
  int error_cnt = 0, checked = 0, cyc = 0;
  always #20 mclk = ~mclk;
  assign pin = pr & !oe;
  assign line = lr & !doe;
  irq_peripherals i_irq_peripherals (.mclk, .rst, .raise, .ack, .req);
  irq_nmi_request_front_end i_irq_nmi_request_front_end (.mclk, .rst, .io_req_in(req), .io_req_ack(ack),
    .io_req_pending(pend), .nmi_src(src), .nmi_enable(en), .nmi_status_clear(clr), .nmi_clear_mask(mask),
    .nmi_status(stat), .nmi_out(nout), .ext_kbd_sel(ext), .kbd_clock_or_request_pin_i(pin),
    .kbd_clock_drive_low(cd), .kbd_clock_or_request_pin_o(po), .kbd_clock_or_request_pin_oe(oe),
    .kbd_serial_clock(kclk), .shared_request_one(sr), .shared_request_one_ack(ack1), .kbd_serial_line_i(line),
    .kbd_data_drive_low(dd), .kbd_serial_line_o(lo), .kbd_serial_line_oe(doe), .kbd_serial_data(kd));
  ////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    {s1, s2, sp, r_prev, pprev} <= rst ? '0 : {src, s1, s2, req, pin};
    e_pend <= rst ? '0 : (e_pend & ~ack) | (req & ~r_prev);
    e_stat <= rst ? '0 : (e_stat & ~(mask & {3{clr}})) | (s2 & ~sp & en);
    e_sr <= (rst || !ext) ? 1'b0 : (e_sr & !ack1) | (pin & !pprev);
    e_kd <= rst ? 1'b1 : ext ? e_kd : line;
  end
  always @(posedge mclk) if (++cyc == 1700) begin error_cnt++; wrap_up; end
  task automatic chk(input logic [5:0] seen, exp);
    checked++;
    if (seen !== exp) begin error_cnt++; $display("BAD %0t seen %h want %h", $time, seen, exp); end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'he760));
    repeat (10) @(negedge mclk);
    rst = 0;
    for (int i = 0; i < 1500; i++) begin
      @(negedge mclk);
      chk(pend, e_pend);
      chk(stat, e_stat);
      chk(nout, |e_stat);
      chk({kclk, oe, sr}, {!ext & pin, !ext & cd, e_sr});
      chk({doe, kd}, {!ext & dd, e_kd});
      chk({po, lo}, 2'h0);
      {raise, ack, src, en, clr, mask, ack1, cd, dd, lr} = $urandom;
      // pin held low when the mode flips so edge history cannot differ
      pr = $urandom_range(1) && (i % 32 != 0);
      ext = i[5];
    end
    wrap_up;
  end
endmodule // testbench
